// ==== ch_synth_map.svh ====
// register offsets, reset values and field positions of the channel bank
// assumes an 8-bit register port with a 4-bit register index
`ifndef CH_SYNTH_MAP_SVH
`define CH_SYNTH_MAP_SVH
`define A_SPACING   4'h0
`define A_BASE_LO   4'h1
`define A_BASE_HI   4'h2
`define A_CHAN_LO   4'h3
`define A_CHAN_MODE 4'h4
`define A_PLL       4'h5
`define A_CAL       4'h6
`define A_OSC       4'h7
`define R_SPACING   8'h08
`define R_BASE_LO   8'hf8
`define R_BASE_HI   8'h8c
`define R_CHAN_LO   8'h00
`define R_CHAN_MODE 8'h00
`define R_PLL       8'h08
`define R_CAL       6'h00
`define R_OSC       8'h10
`define PLL_RW_MASK 8'h3d
`define PLL_LOCK    1
`define PLL_LBW     5:4
`define MODE_SCHEME 7:6
`define MODE_MSB    0
`define OSC_FS      4
`define OSC_TRIM    3:0
`define OSC_MASK    8'h1f
`endif

// ==== ch_synth_pkg.sv ====
// types shared by the channel and synthesizer configuration bank
// assumes nothing beyond a sv-2012 compiler
package ch_synth_pkg;
  typedef enum logic [1:0] {
    SCHEME_IEEE, SCHEME_FINE_400, SCHEME_FINE_800, SCHEME_FINE_2G4
  } scheme_t;
endpackage

// ==== channel_synth_config_regs.sv ====
// channel, synthesizer and oscillator configuration registers
// assumes an spi decoder in front giving one-cycle read/write strobes
`timescale 1ns/1ps
`include "ch_synth_map.svh"
module channel_synth_config_regs (
  input  wire logic                  core_clk,
  input  wire logic                  resetn,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [3:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  output logic      [7:0]            reg_rdata,
  input  wire logic                  band_is_2g4,
  input  wire logic                  radio_off_state,
  input  wire logic                  transmit_prepare_state,
  input  wire logic                  synth_locked,
  input  wire logic                  cal_done,
  input  wire logic [5:0]            cal_result,
  output logic                       cal_start,
  output ch_synth_pkg::scheme_t      channel_scheme_select,
  output logic      [15:0]           act_base_freq,
  output logic      [8:0]            act_chan_num,
  output logic      [7:0]            act_spacing,
  output logic      [23:0]           synth_word,
  output logic      [1:0]            loop_bw_adjust,
  output logic      [3:0]            osc_trim,
  output logic                       fast_start_enable,
  output logic                       radio_ready_irq,
  output logic                       radio_error_irq
);
  import ch_synth_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  logic [7:0]  spacing, base_lo, base_hi, chan_lo, mode, pll, osc;
  logic [7:0]  next_spacing, next_base_lo, next_base_hi, next_chan_lo;
  logic [7:0]  next_mode, next_pll, next_osc, next_rdata;
  logic [5:0]  center_cal_value, next_cal;
  logic [15:0] next_act_base;
  logic [8:0]  next_act_chan;
  logic [7:0]  next_act_spacing;
  logic [23:0] next_word;
  logic        next_cal_start, was_off, was_locked;
  logic        next_ready, next_error;
  logic        wr_apply;

  // ieee word needs 18 bits: 65535 + 511 * 255
  function automatic logic [23:0] channel_word(
    input logic [1:0] scheme, input logic [15:0] base,
    input logic [8:0] cn, input logic [7:0] cs, input logic [7:0] lo);
    logic [16:0] prod;
    prod = 17'(cn * cs);
    if (scheme == 2'(SCHEME_IEEE))
      channel_word = 24'(base) + 24'(prod);
    else
      channel_word = {base, lo};
  endfunction

  assign wr_apply = reg_wr && (reg_addr == `A_CHAN_MODE);
  // the analog loop ignores this field on the 2.4 ghz synthesizer
  assign loop_bw_adjust = band_is_2g4 ? 2'h0 : pll[`PLL_LBW];
  assign osc_trim = osc[`OSC_TRIM];
  assign fast_start_enable = osc[`OSC_FS];

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_spacing = spacing;
    next_base_lo = base_lo;
    next_base_hi = base_hi;
    next_chan_lo = chan_lo;
    next_mode = mode;
    next_pll = pll;
    next_osc = osc;
    if (reg_wr) begin
      unique case (reg_addr)
        `A_SPACING:   next_spacing = reg_wdata;
        `A_BASE_LO:   next_base_lo = reg_wdata;
        `A_BASE_HI:   next_base_hi = reg_wdata;
        `A_CHAN_LO:   next_chan_lo = reg_wdata;
        `A_CHAN_MODE: next_mode = reg_wdata;
        `A_PLL: next_pll = reg_wdata & `PLL_RW_MASK;
        `A_OSC: next_osc = reg_wdata & `OSC_MASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      spacing <= `R_SPACING;
      base_lo <= `R_BASE_LO;
      base_hi <= `R_BASE_HI;
      chan_lo <= `R_CHAN_LO;
      mode <= `R_CHAN_MODE;
      pll <= `R_PLL;
      osc <= `R_OSC;
    end else begin
      spacing <= next_spacing;
      base_lo <= next_base_lo;
      base_hi <= next_base_hi;
      chan_lo <= next_chan_lo;
      mode <= next_mode;
      pll <= next_pll;
      osc <= next_osc;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pending bytes reach the synthesizer only here, so a half-written
  // channel never retunes the loop
  always_comb begin
    next_act_base = act_base_freq;
    next_act_chan = act_chan_num;
    next_act_spacing = act_spacing;
    next_word = synth_word;
    if (wr_apply) begin
      next_act_base = {base_hi, base_lo};
      next_act_chan = {reg_wdata[`MODE_MSB], chan_lo};
      next_act_spacing = spacing;
      next_word = channel_word(reg_wdata[`MODE_SCHEME],
        {base_hi, base_lo}, {reg_wdata[`MODE_MSB], chan_lo},
        spacing, chan_lo);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      act_base_freq <= {`R_BASE_HI, `R_BASE_LO};
      act_chan_num <= 9'h000;
      act_spacing <= `R_SPACING;
      synth_word <= 24'(16'({`R_BASE_HI, `R_BASE_LO}));
      channel_scheme_select <= SCHEME_IEEE;
    end else begin
      act_base_freq <= next_act_base;
      act_chan_num <= next_act_chan;
      act_spacing <= next_act_spacing;
      synth_word <= next_word;
      if (wr_apply)
        channel_scheme_select <= scheme_t'(reg_wdata[`MODE_SCHEME]);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_cal_start = wr_apply ||
      (was_off && transmit_prepare_state);
    next_cal = cal_done ? cal_result : center_cal_value;
    next_ready = transmit_prepare_state && synth_locked &&
      !was_locked;
    next_error = was_locked && !synth_locked;
    next_rdata = reg_rdata;
    if (reg_rd) begin
      unique case (reg_addr)
        `A_SPACING:   next_rdata = spacing;
        `A_BASE_LO:   next_rdata = base_lo;
        `A_BASE_HI:   next_rdata = base_hi;
        `A_CHAN_LO:   next_rdata = chan_lo;
        `A_CHAN_MODE: next_rdata = mode;
        `A_PLL: begin
          next_rdata = pll;
          next_rdata[`PLL_LOCK] = synth_locked;
        end
        `A_CAL: next_rdata = {2'h0, center_cal_value};
        `A_OSC: next_rdata = osc;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cal_start <= 1'b0;
      center_cal_value <= `R_CAL;
      radio_ready_irq <= 1'b0;
      radio_error_irq <= 1'b0;
      reg_rdata <= 8'h00;
      was_off <= 1'b0;
      was_locked <= 1'b0;
    end else begin
      cal_start <= next_cal_start;
      center_cal_value <= next_cal;
      radio_ready_irq <= next_ready;
      radio_error_irq <= next_error;
      reg_rdata <= next_rdata;
      was_off <= radio_off_state;
      was_locked <= synth_locked;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking

  a_reset_base: assert property (!resetn |=>
    {base_hi, base_lo} == {`R_BASE_HI, `R_BASE_LO} &&
    act_base_freq == {`R_BASE_HI, `R_BASE_LO})
    else $error("base not 8cf8 after reset");
  a_pending_hold: assert property (disable iff (!resetn)
    !wr_apply |=> $stable(act_base_freq) && $stable(act_chan_num)
    && $stable(act_spacing))
    else $error("active channel changed without mode write");
  a_apply_all: assert property (disable iff (!resetn)
    wr_apply |=> act_base_freq == $past({base_hi, base_lo})
    && act_spacing == $past(spacing))
    else $error("apply did not take pending values");
  a_chan_bits: assert property (disable iff (!resetn)
    wr_apply |=> act_chan_num == {$past(reg_wdata[0]), $past(chan_lo)})
    else $error("channel number not assembled");
  a_ieee_word: assert property (disable iff (!resetn)
    wr_apply && reg_wdata[7:6] == 2'h0 |=> synth_word ==
    24'(act_base_freq) + 24'(act_chan_num) * 24'(act_spacing))
    else $error("ieee word wrong");
  a_fine_word: assert property (disable iff (!resetn)
    wr_apply && reg_wdata[7:6] != 2'h0 |=>
    synth_word == {act_base_freq, act_chan_num[7:0]})
    else $error("fine word wrong");
  a_loop_band: assert property (disable iff (!resetn)
    band_is_2g4 |-> loop_bw_adjust == 2'h0)
    else $error("loop bandwidth leaked to 2.4 ghz");
  a_lock_read: assert property (disable iff (!resetn)
    reg_rd && reg_addr == `A_PLL |=>
    reg_rdata[1] == $past(synth_locked) && reg_rdata[7:6] == 2'h0)
    else $error("lock flag read wrong");
  a_ro_bits: assert property (disable iff (!resetn)
    reg_wr && reg_addr == `A_PLL |=> pll[7:6] == 2'h0 && pll[1] == 1'b0)
    else $error("read-only synth bit written");
  a_cal_start: assert property (disable iff (!resetn)
    wr_apply |=> cal_start)
    else $error("channel change did not start calibration");
  a_cal_capture: assert property (disable iff (!resetn)
    cal_done |=> center_cal_value == $past(cal_result))
    else $error("calibration result not captured");
  a_err_irq: assert property (disable iff (!resetn)
    was_locked && !synth_locked |=> radio_error_irq && !radio_ready_irq)
    else $error("lock loss not reported");
  a_osc_trim: assert property (disable iff (!resetn)
    reg_wr && reg_addr == `A_OSC |=> osc_trim == $past(reg_wdata[3:0])
    && fast_start_enable == $past(reg_wdata[4]))
    else $error("oscillator control not updated");

  c_apply: cover property (disable iff (!resetn)
    wr_apply ##1 cal_start);
  c_relock: cover property (disable iff (!resetn)
    radio_error_irq ##[1:20] radio_ready_irq);
  c_fine: cover property (disable iff (!resetn)
    wr_apply && reg_wdata[7:6] == 2'h3);
endmodule

// ==== radio_analog_model.sv ====
// analog stand-in: answers calibration requests of the channel bank
// assumes one-cycle cal_start pulses on core_clk
`timescale 1ns/1ps
module radio_analog_model #(
  parameter logic [5:0] CAL_SEED = 6'h2b,
  parameter int         CAL_LAT  = 3
) (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       cal_start,
  output logic            cal_done = 1'b0,
  output logic      [5:0] cal_result = 6'h00
);
  int         wait_cnt = 0;
  logic [5:0] next_val;
  // result line flips every cycle outside the done pulse, so a capture
  // one cycle late can never pass for a good one
  always @(posedge core_clk) begin
    cal_done   <= 1'b0;
    cal_result <= ~cal_result;
    if (!resetn) begin
      wait_cnt <= 0;
      next_val <= CAL_SEED;
    end else if (cal_start) begin
      wait_cnt <= CAL_LAT;
    end else if (wait_cnt == 1) begin
      wait_cnt   <= 0;
      cal_done   <= 1'b1;
      cal_result <= next_val;
      next_val   <= next_val + 6'h01;
    end else if (wait_cnt > 1) begin
      wait_cnt <= wait_cnt - 1;
    end
  end
endmodule

// ==== channel_synth_config_regs_tb.sv ====
// bench for the channel bank: register strobes driven as the host
// assumes the analog stand-in model answers calibration requests
`timescale 1ns/1ps
`include "ch_synth_map.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  bad_count++; $display("mismatch %s expected %h seen %h", nm, e, g); \
  end end
module channel_synth_config_regs_tb;
  import ch_synth_pkg::*;
  localparam logic [5:0] SEED = 6'h2b;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        band_is_2g4 = 1'b0;
  logic        off_st = 1'b1;
  logic        prep_st = 1'b0;
  logic        synth_locked = 1'b0;
  logic        cal_done, cal_start, ready_irq, error_irq, fast_start;
  logic [5:0]  cal_result, ev;
  logic [7:0]  reg_rdata, act_spacing;
  scheme_t     scheme;
  logic [15:0] act_base;
  logic [8:0]  act_chan;
  logic [23:0] synth_word;
  logic [1:0]  loop_bw;
  logic [3:0]  osc_trim;
  int          bad_count = 0;
  int          n_compared = 0;
  int          n_rdy = 0, n_err = 0, n_cal = 0, n_done = 0, cycles = 0;
  ////////////////////////////////////////////////////////////
  channel_synth_config_regs u_dut (
    .core_clk(core_clk), .resetn(resetn), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .band_is_2g4(band_is_2g4),
    .radio_off_state(off_st), .transmit_prepare_state(prep_st),
    .synth_locked(synth_locked), .cal_done(cal_done),
    .cal_result(cal_result), .cal_start(cal_start),
    .channel_scheme_select(scheme), .act_base_freq(act_base),
    .act_chan_num(act_chan), .act_spacing(act_spacing),
    .synth_word(synth_word), .loop_bw_adjust(loop_bw),
    .osc_trim(osc_trim), .fast_start_enable(fast_start),
    .radio_ready_irq(ready_irq), .radio_error_irq(error_irq));
  radio_analog_model #(.CAL_SEED(SEED), .CAL_LAT(3)) u_model (
    .core_clk(core_clk), .resetn(resetn), .cal_start(cal_start),
    .cal_done(cal_done), .cal_result(cal_result));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  // pulse tallies stand in for exact-cycle probes of one-cycle outputs
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    n_rdy  <= n_rdy + (ready_irq === 1'b1 ? 1 : 0);
    n_err  <= n_err + (error_irq === 1'b1 ? 1 : 0);
    n_cal  <= n_cal + (cal_start === 1'b1 ? 1 : 0);
    n_done <= n_done + (cal_done === 1'b1 ? 1 : 0);
    if (cycles == 2000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop;
    if (bad_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e,
                        input string nm);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    `CHK(nm, e, reg_rdata)
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    cyc(20);
    resetn <= 1'b1;
    rd_chk(`A_SPACING, `R_SPACING, "spacing");
    rd_chk(`A_BASE_LO, 8'hf8, "base_lo");
    rd_chk(`A_BASE_HI, 8'h8c, "base_hi");
    rd_chk(`A_PLL, 8'h08, "pll");
    rd_chk(`A_OSC, `R_OSC, "osc_rst");
    `CHK("base", 16'h8cf8, act_base)
    wr(`A_SPACING, 8'h30);
    wr(`A_BASE_LO, 8'hf1);
    wr(`A_BASE_HI, 8'h86);
    wr(`A_CHAN_LO, 8'h02);
    @(negedge core_clk);
    `CHK("pend_base", 16'h8cf8, act_base)
    `CHK("pend_cs", `R_SPACING, act_spacing)
    rd_chk(`A_CHAN_LO, 8'h02, "chan_lo");
    wr(`A_CHAN_MODE, 8'h00);
    @(negedge core_clk);
    `CHK("base", 16'h86f1, act_base)
    `CHK("cs", 8'h30, act_spacing)
    `CHK("word", 24'h008751, synth_word)
    `CHK("scheme", SCHEME_IEEE, scheme)
    `CHK("cal_go", 1'b1, cal_start)
    wr(`A_CHAN_MODE, 8'h01);
    @(negedge core_clk);
    `CHK("chan", 9'h102, act_chan)
    `CHK("word", 24'h00b751, synth_word)
    for (int s = 1; s < 4; s++) begin
      wr(`A_CHAN_MODE, {s[1:0], 6'h00});
      @(negedge core_clk);
      `CHK("scheme", scheme_t'(s), scheme)
      `CHK("fine", 24'h86f102, synth_word)
    end
    rd_chk(`A_CHAN_MODE, 8'hc0, "mode");
    cyc(8);
    `CHK("cal_cnt", 5, n_cal)
    ev = SEED + 6'(n_done - 1);
    rd_chk(`A_CAL, {2'b00, ev}, "cal_val");
    @(posedge core_clk);
    off_st  <= 1'b0;
    prep_st <= 1'b1;
    synth_locked <= 1'b1;
    cyc(8);
    `CHK("cal_cnt", 6, n_cal)
    `CHK("rdy", 1, n_rdy)
    synth_locked <= 1'b0;
    cyc(4);
    `CHK("err", 1, n_err)
    `CHK("rdy", 1, n_rdy)
    synth_locked <= 1'b1;
    cyc(3);
    `CHK("relock", 2, n_rdy)
    prep_st <= 1'b0;
    off_st  <= 1'b1;
    synth_locked <= 1'b0;
    cyc(2);
    synth_locked <= 1'b1;
    cyc(4);
    `CHK("rdy_off", 2, n_rdy)
    `CHK("err_off", 2, n_err)
    wr(`A_PLL, 8'hff);
    rd_chk(`A_PLL, 8'h3f, "pll_rw");
    for (int v = 0; v < 3; v++) begin
      wr(`A_PLL, {2'b00, v[1:0], 4'h8});
      @(negedge core_clk);
      `CHK("lbw", v[1:0], loop_bw)
    end
    @(posedge core_clk);
    band_is_2g4 <= 1'b1;
    synth_locked <= 1'b0;
    @(negedge core_clk);
    `CHK("lbw_2g4", 2'b00, loop_bw)
    rd_chk(`A_PLL, 8'h28, "pll_unlk");
    wr(`A_OSC, 8'hff);
    rd_chk(`A_OSC, 8'h1f, "osc");
    wr(`A_OSC, 8'h05);
    @(negedge core_clk);
    `CHK("trim", 4'h5, osc_trim)
    `CHK("fs", 1'b0, fast_start)
    wr(4'hf, 8'h55);
    rd_chk(4'hf, 8'h00, "unmapped");
    @(posedge core_clk);
    resetn <= 1'b0;
    cyc(2);
    resetn <= 1'b1;
    rd_chk(`A_BASE_LO, 8'hf8, "base_lo");
    report_and_stop();
  end
endmodule
